// >>> rtl/ssd_map.vh
// Register map, field positions and reset values of the sampler state decoder.
`ifndef SSD_MAP_VH
`define SSD_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SSD_GEN_OFS 10'h000
`define SSD_KEY_OFS 10'h010
`define SSD_STAT_OFS 10'h020
`define SSD_SCL_OFS 10'h100

// ------------------------------------------------------------
// Scaling-sample state array geometry
// ------------------------------------------------------------
`define SSD_SCL_ELEMS 4
`define SSD_SCL_STRIDE_DW 16
`define SSD_SCL_KEPT_DW 5
`define SSD_SCL_ALIGN_BYTES 32

// ------------------------------------------------------------
// General sampler state fields
// ------------------------------------------------------------
`define SSD_GEN_KEY_EN 25
`define SSD_GEN_KEY_IDX_HI 24
`define SSD_GEN_KEY_IDX_LO 23
`define SSD_GEN_KEY_MODE 22
`define SSD_GEN_ANISO_HI 21
`define SSD_GEN_ANISO_LO 19
`define SSD_GEN_ROUND_HI 18
`define SSD_GEN_ROUND_LO 13
`define SSD_GEN_UNNORM 0
`define SSD_GEN_RST 32'h0000_0000
`define SSD_GEN_WMASK 32'h03ff_e001

// ------------------------------------------------------------
// Scaling-sample state fields
// ------------------------------------------------------------
`define SSD_D0_KERNEL 31
`define SSD_D0_BYPASS 29
`define SSD_D0_KEY_EN 18
`define SSD_D0_KEY_IDX_HI 17
`define SSD_D0_KEY_IDX_LO 16
`define SSD_D0_WMASK 32'ha007_0000
`define SSD_D1_WMASK 32'hffff_ffe0
`define SSD_D2_WMASK 32'h0000_ffff
`define SSD_D3_WMASK 32'h777f_c7df
`define SSD_D4_WMASK 32'h7df0_0000
`define SSD_D0_RST 32'h0000_0000
`define SSD_D1_RST 32'h0000_0000
`define SSD_D2_RST 32'h0000_1681
`define SSD_D3_RST 32'h721a_03c6
`define SSD_D4_RST 32'h0c80_0000

// ------------------------------------------------------------
// Key replacement values (8-bit scale)
// ------------------------------------------------------------
`define SSD_BLACK_CHROMA 8'h80
`define SSD_BLACK_LUMA 8'h10

`endif

// >>> rtl/ssd_key_filter.v
// Chroma-key compare and replace-black substitution for one texel.
`timescale 1ns/10ps
`include "ssd_map.vh"

module ssd_key_filter (
  // Control
  input wire key_on,
  input wire replace_black,
  input wire fmt_yuv,
  input wire fmt_ten_bit,
  input wire [23:0] key_value,
  // Texel in
  input wire [9:0] tex_a,
  input wire [9:0] tex_r,
  input wire [9:0] tex_g,
  input wire [9:0] tex_b,
  // Texel out
  output wire key_match,
  output wire [9:0] out_a,
  output wire [9:0] out_r,
  output wire [9:0] out_g,
  output wire [9:0] out_b
);

  wire [7:0] cmp_r;
  wire [7:0] cmp_g;
  wire [7:0] cmp_b;
  wire [7:0] blk_c;
  wire [7:0] blk_y;
  wire [9:0] blk_r;
  wire [9:0] blk_g;
  wire do_replace;

  // Ten-bit texels are keyed on their eight upper bits only.
  assign cmp_r = fmt_ten_bit ? tex_r[9:2] : tex_r[7:0];
  assign cmp_g = fmt_ten_bit ? tex_g[9:2] : tex_g[7:0];
  assign cmp_b = fmt_ten_bit ? tex_b[9:2] : tex_b[7:0];
  assign key_match = key_on && (cmp_r == key_value[23:16]) &&
                     (cmp_g == key_value[15:8]) && (cmp_b == key_value[7:0]);

  assign blk_c = fmt_yuv ? `SSD_BLACK_CHROMA : 8'h00;
  assign blk_y = fmt_yuv ? `SSD_BLACK_LUMA : 8'h00;
  assign blk_r = fmt_ten_bit ? {blk_c, 2'b00} : {2'b00, blk_c};
  assign blk_g = fmt_ten_bit ? {blk_y, 2'b00} : {2'b00, blk_y};
  assign do_replace = key_match && replace_black;

  // A matching texel in replace-black mode becomes transparent black before filtering.
  assign out_a = do_replace ? 10'h000 : tex_a;
  assign out_r = do_replace ? blk_r : tex_r;
  assign out_g = do_replace ? blk_g : tex_g;
  assign out_b = do_replace ? blk_r : tex_b;

endmodule

// >>> rtl/ssd_edge_class.v
// Edge classification and sharpening weight choice for the adaptive sharpener.
`timescale 1ns/10ps

module ssd_edge_class #(
  parameter EM_W = 8
) (
  // Measure and thresholds
  input wire [EM_W-1:0] edge_measure,
  input wire [3:0] strong_thr,
  input wire [3:0] weak_thr,
  // Weights
  input wire [2:0] strong_wt,
  input wire [2:0] weak_wt,
  input wire [2:0] none_wt,
  input wire neutral,
  // Result
  output reg [1:0] edge_class,
  output reg [2:0] sharp_weight
);

  wire [EM_W-1:0] s_ext;
  wire [EM_W-1:0] w_ext;

  assign s_ext = {{(EM_W-4){1'b0}}, strong_thr};
  assign w_ext = {{(EM_W-4){1'b0}}, weak_thr};

  always @* begin
    if (edge_measure > s_ext) begin
      edge_class = 2'h2;
      sharp_weight = strong_wt;
    end else if ((edge_measure > w_ext) && (edge_measure < s_ext)) begin
      edge_class = 2'h1;
      sharp_weight = weak_wt;
    end else begin
      edge_class = 2'h0;
      sharp_weight = none_wt;
    end
    if (neutral) begin
      sharp_weight = 3'h0;
    end
  end

endmodule

// >>> rtl/ssd_top.v
// Sampler state decoder: state registers, message decode and keyed texel path.
`timescale 1ns/10ps
`include "ssd_map.vh"

module ssd_top #(
  parameter EM_W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Sampling message, one texel per beat
  input wire msg_valid,
  input wire msg_scaling,
  input wire [3:0] msg_sampler_index,
  input wire msg_last,
  input wire msg_kill_return,
  input wire msg_green_masked,
  input wire msg_minify,
  input wire msg_fmt_yuv,
  input wire msg_fmt_ten_bit,
  input wire [9:0] msg_tex_a,
  input wire [9:0] msg_tex_r,
  input wire [9:0] msg_tex_g,
  input wire [9:0] msg_tex_b,
  input wire [EM_W-1:0] msg_edge_measure,
  // Texel result
  output reg out_valid,
  output reg [9:0] out_tex_a,
  output reg [9:0] out_tex_r,
  output reg [9:0] out_tex_g,
  output reg [9:0] out_tex_b,
  output reg out_pixel_done,
  output reg out_pixel_mask,
  output reg out_mask_valid,
  // General sampler controls
  output reg [4:0] out_ratio_limit,
  output reg [2:0] out_round_uvr,
  output reg out_unnorm_coords,
  // Scaling controls
  output reg out_kernel_nearest,
  output reg out_enh_bypass,
  output reg out_enh_detail_5x5,
  output reg [31:0] out_detail_ptr,
  output reg [1:0] out_edge_class,
  output reg [2:0] out_sharp_weight,
  output reg [5:0] out_gain,
  output reg [7:0] out_noise_est,
  output reg [4:0] out_inner_ring_centre_coef,
  output reg [4:0] out_inner_ring_cross_coef,
  output reg [4:0] out_outer_ring_centre_coef,
  output reg [4:0] out_outer_ring_cross_coef
);

  // ------------------------------------------------------------
  // State storage
  // ------------------------------------------------------------
  reg [31:0] gen_r;
  reg [23:0] key_tab_r [0:3];
  reg [31:0] scl_mem_r [0:`SSD_SCL_ELEMS*`SSD_SCL_KEPT_DW-1];
  reg [15:0] msg_count_r;
  reg [1:0] last_elem_r;
  reg match_any_r;
  integer i;
  integer j;

  function [4:0] scl_slot;
    input [1:0] elem;
    input [2:0] dw;
    begin
      scl_slot = {1'b0, elem, 2'b00} + {3'b000, elem} + {2'b00, dw};
    end
  endfunction

  function [31:0] scl_wmask;
    input [2:0] dw;
    begin
      case (dw)
        3'h0: scl_wmask = `SSD_D0_WMASK;
        3'h1: scl_wmask = `SSD_D1_WMASK;
        3'h2: scl_wmask = `SSD_D2_WMASK;
        3'h3: scl_wmask = `SSD_D3_WMASK;
        3'h4: scl_wmask = `SSD_D4_WMASK;
        default: scl_wmask = 32'h0000_0000;
      endcase
    end
  endfunction

  function [31:0] scl_rst;
    input [2:0] dw;
    begin
      case (dw)
        3'h0: scl_rst = `SSD_D0_RST;
        3'h1: scl_rst = `SSD_D1_RST;
        3'h2: scl_rst = `SSD_D2_RST;
        3'h3: scl_rst = `SSD_D3_RST;
        3'h4: scl_rst = `SSD_D4_RST;
        default: scl_rst = 32'h0000_0000;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire bus_req;
  wire [31:0] sel_mask;
  wire hit_gen;
  wire hit_key;
  wire hit_stat;
  wire hit_scl;
  wire [1:0] bus_elem;
  wire [3:0] bus_dw;
  wire scl_kept;
  wire [4:0] bus_slot;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign hit_gen = (wb_adr_i[9:2] == `SSD_GEN_OFS >> 2);
  assign hit_key = (wb_adr_i[9:4] == `SSD_KEY_OFS >> 4);
  assign hit_stat = (wb_adr_i[9:2] == `SSD_STAT_OFS >> 2);
  assign hit_scl = (wb_adr_i[9:8] == `SSD_SCL_OFS >> 8);
  // Each element spans sixteen dwords; only the first five hold state.
  assign bus_elem = wb_adr_i[7:6];
  assign bus_dw = wb_adr_i[5:2];
  assign scl_kept = (bus_dw < `SSD_SCL_KEPT_DW);
  assign bus_slot = scl_slot(bus_elem, bus_dw[2:0]);

  always @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      gen_r <= `SSD_GEN_RST;
      for (i = 0; i < 4; i = i + 1) begin
        key_tab_r[i] <= 24'h00_0000;
      end
      for (i = 0; i < `SSD_SCL_ELEMS; i = i + 1) begin
        for (j = 0; j < `SSD_SCL_KEPT_DW; j = j + 1) begin
          scl_mem_r[i * `SSD_SCL_KEPT_DW + j] <= scl_rst(j[2:0]);
        end
      end
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && wb_we_i) begin
        if (hit_gen) begin
          gen_r <= (gen_r & ~(sel_mask & `SSD_GEN_WMASK)) |
                   (wb_dat_i & sel_mask & `SSD_GEN_WMASK);
        end
        if (hit_key) begin
          key_tab_r[wb_adr_i[3:2]] <= (key_tab_r[wb_adr_i[3:2]] & ~sel_mask[23:0]) |
                                      (wb_dat_i[23:0] & sel_mask[23:0]);
        end
        // Reserved and ignored bits, the pointer's low five among them, stay zero.
        if (hit_scl && scl_kept) begin
          scl_mem_r[bus_slot] <= (scl_mem_r[bus_slot] &
                                  ~(sel_mask & scl_wmask(bus_dw[2:0]))) |
                                 (wb_dat_i & sel_mask & scl_wmask(bus_dw[2:0]));
        end
      end else if (bus_req) begin
        if (hit_gen) begin
          wb_dat_o <= gen_r;
        end else if (hit_key) begin
          wb_dat_o <= {8'h00, key_tab_r[wb_adr_i[3:2]]};
        end else if (hit_stat) begin
          wb_dat_o <= {12'h000, match_any_r, 1'b0, last_elem_r, msg_count_r};
        end else if (hit_scl && scl_kept) begin
          wb_dat_o <= scl_mem_r[bus_slot];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Message decode
  // ------------------------------------------------------------
  wire [1:0] msg_elem;
  wire [31:0] sd0;
  wire [31:0] sd1;
  wire [31:0] sd2;
  wire [31:0] sd3;
  wire [31:0] sd4;
  wire key_on;
  wire replace_black;
  wire [1:0] key_idx;
  wire enh_bypass;
  wire [2:0] round_sel;
  wire tex_match;
  wire [9:0] kf_a;
  wire [9:0] kf_r;
  wire [9:0] kf_g;
  wire [9:0] kf_b;
  wire [1:0] ec_class;
  wire [2:0] ec_weight;
  wire pixel_hit;

  // The element index is the message's sampler index divided by four.
  assign msg_elem = msg_sampler_index[3:2];
  assign sd0 = scl_mem_r[scl_slot(msg_elem, 3'h0)];
  assign sd1 = scl_mem_r[scl_slot(msg_elem, 3'h1)];
  assign sd2 = scl_mem_r[scl_slot(msg_elem, 3'h2)];
  assign sd3 = scl_mem_r[scl_slot(msg_elem, 3'h3)];
  assign sd4 = scl_mem_r[scl_slot(msg_elem, 3'h4)];

  assign key_on = msg_scaling ? sd0[`SSD_D0_KEY_EN] : gen_r[`SSD_GEN_KEY_EN];
  assign replace_black = msg_scaling ? 1'b1 : gen_r[`SSD_GEN_KEY_MODE];
  // With keying off the index is forced to entry zero and never used.
  assign key_idx = !key_on ? 2'h0 :
                   msg_scaling ? sd0[`SSD_D0_KEY_IDX_HI:`SSD_D0_KEY_IDX_LO] :
                   gen_r[`SSD_GEN_KEY_IDX_HI:`SSD_GEN_KEY_IDX_LO];
  assign enh_bypass = sd0[`SSD_D0_BYPASS] || msg_green_masked;

  // Mask bits from the top: U mag, U min, V mag, V min, R mag, R min.
  assign round_sel = msg_minify ?
                     {gen_r[17], gen_r[15], gen_r[13]} :
                     {gen_r[18], gen_r[16], gen_r[14]};

  ssd_key_filter u_key (
    .key_on(key_on),
    .replace_black(replace_black),
    .fmt_yuv(msg_fmt_yuv),
    .fmt_ten_bit(msg_fmt_ten_bit),
    .key_value(key_tab_r[key_idx]),
    .tex_a(msg_tex_a),
    .tex_r(msg_tex_r),
    .tex_g(msg_tex_g),
    .tex_b(msg_tex_b),
    .key_match(tex_match),
    .out_a(kf_a),
    .out_r(kf_r),
    .out_g(kf_g),
    .out_b(kf_b)
  );

  ssd_edge_class #(
    .EM_W(EM_W)
  ) u_edge (
    .edge_measure(msg_edge_measure),
    .strong_thr(sd2[7:4]),
    .weak_thr(sd2[3:0]),
    .strong_wt(sd3[30:28]),
    .weak_wt(sd3[26:24]),
    .none_wt(sd3[22:20]),
    .neutral(enh_bypass),
    .edge_class(ec_class),
    .sharp_weight(ec_weight)
  );

  // A pixel is killed if any texel feeding it matched outside replace-black mode, across all its beats.
  assign pixel_hit = match_any_r || (tex_match && !replace_black);

  // ------------------------------------------------------------
  // Result stage
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_tex_a <= 10'h000;
      out_tex_r <= 10'h000;
      out_tex_g <= 10'h000;
      out_tex_b <= 10'h000;
      out_pixel_done <= 1'b0;
      out_pixel_mask <= 1'b1;
      out_mask_valid <= 1'b0;
      out_ratio_limit <= 5'h02;
      out_round_uvr <= 3'h0;
      out_unnorm_coords <= 1'b0;
      out_kernel_nearest <= 1'b0;
      out_enh_bypass <= 1'b0;
      out_enh_detail_5x5 <= 1'b1;
      out_detail_ptr <= 32'h0000_0000;
      out_edge_class <= 2'h0;
      out_sharp_weight <= 3'h0;
      out_gain <= 6'h00;
      out_noise_est <= 8'h00;
      out_inner_ring_centre_coef <= 5'h00;
      out_inner_ring_cross_coef <= 5'h00;
      out_outer_ring_centre_coef <= 5'h00;
      out_outer_ring_cross_coef <= 5'h00;
      match_any_r <= 1'b0;
      msg_count_r <= 16'h0000;
      last_elem_r <= 2'h0;
    end else begin
      out_valid <= msg_valid;
      out_pixel_done <= msg_valid && msg_last;
      out_mask_valid <= msg_valid && msg_last && msg_kill_return;
      if (msg_valid) begin
        msg_count_r <= msg_count_r + 16'h0001;
        out_tex_a <= kf_a;
        out_tex_r <= kf_r;
        out_tex_g <= kf_g;
        out_tex_b <= kf_b;
        if (msg_last) begin
          match_any_r <= 1'b0;
          // The cleared bit shows only when the message asks for the mask back.
          out_pixel_mask <= !(pixel_hit && msg_kill_return);
        end else begin
          match_any_r <= pixel_hit;
        end
        if (msg_scaling) begin
          last_elem_r <= msg_elem;
          out_kernel_nearest <= sd0[`SSD_D0_KERNEL];
          out_enh_bypass <= enh_bypass;
          out_enh_detail_5x5 <= 1'b1;
          out_detail_ptr <= {sd1[31:5], 5'h00};
          out_edge_class <= ec_class;
          out_sharp_weight <= ec_weight;
          out_gain <= enh_bypass ? 6'h00 : sd3[19:14];
          out_noise_est <= sd2[15:8];
          out_inner_ring_centre_coef <= sd3[10:6];
          out_inner_ring_cross_coef <= sd3[4:0];
          out_outer_ring_centre_coef <= sd4[30:26];
          out_outer_ring_cross_coef <= sd4[24:20];
        end else begin
          out_ratio_limit <= {gen_r[21:19], 1'b0} + 5'h02;
          out_round_uvr <= round_sel;
          out_unnorm_coords <= gen_r[`SSD_GEN_UNNORM];
        end
      end
    end
  end

endmodule

// >>> verification/ssd_top_sva.sv
// Port-level assertion checker for the sampler state decoder.
`timescale 1ns/10ps
module ssd_top_sva #(
  parameter EM_W = 8
) (
  // Clock, reset and bus handshake
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Message beat
  input wire logic msg_valid,
  input wire logic msg_scaling,
  input wire logic msg_last,
  input wire logic msg_kill_return,
  input wire logic msg_green_masked,
  // Results
  input wire logic out_valid,
  input wire logic out_pixel_done,
  input wire logic out_pixel_mask,
  input wire logic out_mask_valid,
  input wire logic [4:0] out_ratio_limit,
  input wire logic [31:0] out_detail_ptr,
  input wire logic out_enh_detail_5x5,
  input wire logic out_enh_bypass,
  input wire logic [2:0] out_sharp_weight,
  input wire logic [5:0] out_gain
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged one cycle later");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_beat_answer: assert property (msg_valid |=> out_valid)
    else $error("message beat gave no result");
  a_no_stray_out: assert property (!msg_valid |=> !out_valid)
    else $error("result without a message beat");
  a_pixel_done: assert property (msg_valid && msg_last |=> out_pixel_done)
    else $error("pixel completion missing after last beat");
  a_done_pulse: assert property (!(msg_valid && msg_last) |=> !out_pixel_done)
    else $error("pixel completion without a last beat");
  a_kill_report: assert property (msg_valid && msg_last && msg_kill_return |=> out_mask_valid)
    else $error("killed mask not returned");
  a_ratio_range: assert property (!out_ratio_limit[0] && out_ratio_limit inside {[2:16]})
    else $error("ratio limit out of range");
  a_ptr_aligned: assert property (out_detail_ptr[4:0] == 5'h00)
    else $error("detail pointer low bits not zero");
  a_window_fixed: assert property (out_enh_detail_5x5)
    else $error("enhancement window not fixed");
  a_green_bypass: assert property (msg_valid && msg_scaling && msg_green_masked |=>
    out_enh_bypass && out_sharp_weight == 3'h0 && out_gain == 6'h00)
    else $error("masked luma did not force bypass");

  c_kill: cover property (out_mask_valid && !out_pixel_mask);
  c_bypass: cover property (msg_valid && msg_scaling && msg_green_masked);
  c_back_to_back: cover property (msg_valid ##1 msg_valid && msg_last);
endmodule

bind ssd_top ssd_top_sva #(.EM_W(EM_W)) u_sva (
  .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .msg_valid, .msg_scaling, .msg_last,
  .msg_kill_return, .msg_green_masked, .out_valid, .out_pixel_done, .out_pixel_mask,
  .out_mask_valid, .out_ratio_limit, .out_detail_ptr, .out_enh_detail_5x5, .out_enh_bypass,
  .out_sharp_weight, .out_gain
);

// >>> verification/ssd_eu_model.sv
// Execution unit model that issues sampling message beats.
`timescale 1ns/10ps
module ssd_eu_model (
  // Clock
  input wire logic sys_clk,
  // Message beat
  output logic msg_valid,
  output logic msg_scaling,
  output logic [3:0] msg_sampler_index,
  output logic msg_last,
  output logic msg_kill_return,
  output logic msg_green_masked,
  output logic msg_minify,
  output logic msg_fmt_yuv,
  output logic msg_fmt_ten_bit,
  output logic [9:0] msg_tex_a,
  output logic [9:0] msg_tex_r,
  output logic [9:0] msg_tex_g,
  output logic [9:0] msg_tex_b,
  output logic [7:0] msg_edge_measure
);
  logic [58:0] f_r = '0;
  assign {msg_scaling, msg_sampler_index, msg_last, msg_kill_return, msg_green_masked,
    msg_minify, msg_fmt_yuv, msg_fmt_ten_bit, msg_tex_a, msg_tex_r, msg_tex_g, msg_tex_b,
    msg_edge_measure} = f_r;
  initial msg_valid = 1'b0;

  task automatic go(input logic [1:0] el, input logic [54:0] f);
    @(posedge sys_clk);
    msg_valid <= 1'b1;
    f_r <= {f[54], el, 2'b00, f[53:0]};
  endtask

  // Released fields are inverted so no stale beat content lingers.
  task automatic idle();
    @(posedge sys_clk);
    msg_valid <= 1'b0;
    f_r <= ~f_r;
  endtask
endmodule

// >>> verification/ssd_top_tb_top.sv
// Self-checking bench for the sampler state decoder.
`timescale 1ns/10ps
module ssd_top_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rdat, p, q, d0, d2, d3, d4, kv;
  logic wb_ack_o, msg_valid, msg_scaling, msg_last, msg_kill_return, msg_green_masked;
  logic msg_minify, msg_fmt_yuv, msg_fmt_ten_bit, out_valid, out_pixel_done, out_pixel_mask;
  logic out_mask_valid, out_unnorm_coords, out_kernel_nearest, out_enh_bypass;
  logic out_enh_detail_5x5, gm, mn, u, ten, byp;
  logic [3:0] msg_sampler_index;
  logic [9:0] msg_tex_a, msg_tex_r, msg_tex_g, msg_tex_b;
  logic [9:0] out_tex_a, out_tex_r, out_tex_g, out_tex_b;
  logic [7:0] msg_edge_measure, out_noise_est, em;
  logic [4:0] out_ratio_limit, out_inner_ring_centre_coef, out_inner_ring_cross_coef;
  logic [4:0] out_outer_ring_centre_coef, out_outer_ring_cross_coef;
  logic [2:0] out_round_uvr, out_sharp_weight;
  logic [1:0] out_edge_class;
  logic [5:0] out_gain, rm;
  logic [29:0] hitx;
  logic [31:0] out_detail_ptr;
  logic [31:0] dflt [2:4] = '{32'h0000_1681, 32'h721a_03c6, 32'h0c80_0000};
  int bad_count = 0, comparisons = 0, cyc = 0, c;

  ssd_eu_model eu (.sys_clk, .msg_valid, .msg_scaling, .msg_sampler_index, .msg_last,
    .msg_kill_return, .msg_green_masked, .msg_minify, .msg_fmt_yuv, .msg_fmt_ten_bit,
    .msg_tex_a, .msg_tex_r, .msg_tex_g, .msg_tex_b, .msg_edge_measure);

  ssd_top #(.EM_W(8)) dut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .msg_valid, .msg_scaling, .msg_sampler_index,
    .msg_last, .msg_kill_return, .msg_green_masked, .msg_minify, .msg_fmt_yuv,
    .msg_fmt_ten_bit, .msg_tex_a, .msg_tex_r, .msg_tex_g, .msg_tex_b, .msg_edge_measure,
    .out_valid, .out_tex_a, .out_tex_r, .out_tex_g, .out_tex_b, .out_pixel_done,
    .out_pixel_mask, .out_mask_valid, .out_ratio_limit, .out_round_uvr, .out_unnorm_coords,
    .out_kernel_nearest, .out_enh_bypass, .out_enh_detail_5x5, .out_detail_ptr,
    .out_edge_class, .out_sharp_weight, .out_gain, .out_noise_est,
    .out_inner_ring_centre_coef, .out_inner_ring_cross_coef, .out_outer_ring_centre_coef,
    .out_outer_ring_cross_coef);

  always #2.5 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic bus cycle; read data is taken at the acknowledging edge.
  task automatic acc(input logic we, input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1) @(posedge sys_clk);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic logic [9:0] sa(input int e, input int dw);
    return 10'(32'h100 + e * 64 + dw * 4);
  endfunction

  task automatic beat(input logic [1:0] el, input logic [54:0] f);
    eu.go(el, f);
    eu.idle();
    #1;
  endtask

  initial begin
    void'($urandom(11));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int e = 0; e < 4; e++) begin
      for (int dw = 2; dw < 5; dw++) begin
        acc(1'b0, sa(e, dw), '0, 4'hf);
        chk("dflt", rdat, dflt[dw]);
      end
      acc(1'b1, sa(e, 5), '1, 4'hf);
      acc(1'b0, sa(e, 5), '0, 4'hf);
      chk("hole", rdat, 0);
      // Each element keeps one pointer for all beats that use it.
      p = $urandom;
      acc(1'b1, sa(e, 1), p, 4'hf);
      q = $urandom;
      acc(1'b1, sa(e, 1), q, 4'h1);
      p = {p[31:8], q[7:0]} & 32'hffff_ffe0;
      acc(1'b0, sa(e, 1), '0, 4'hf);
      chk("ptr", rdat, p);
      d0 = $urandom & 32'hb800_0000;
      d2 = $urandom & 32'h0000_ffff;
      d3 = $urandom & 32'h777f_c7df;
      d4 = $urandom & 32'h7df0_0000;
      acc(1'b1, sa(e, 0), d0, 4'hf);
      acc(1'b1, sa(e, 2), d2, 4'hf);
      acc(1'b1, sa(e, 3), d3, 4'hf);
      acc(1'b1, sa(e, 4), d4, 4'hf);
      for (int i = 0; i < 6; i++) begin
        em = 8'(i < 4 ? (i[1] ? d2[7:4] : d2[3:0]) + i[0] : $urandom);
        gm = 1'($urandom);
        beat(2'(e), {1'b1, 2'b00, gm, 43'h0, em});
        byp = d0[29] | gm;
        c = em > d2[7:4] ? 2 : (em > d2[3:0] && em < d2[7:4]) ? 1 : 0;
        chk("kern", out_kernel_nearest, d0[31]);
        chk("win", out_enh_detail_5x5, 1'b1);
        chk("dptr", out_detail_ptr, p);
        chk("byp", out_enh_bypass, byp);
        chk("cls", out_edge_class, c);
        chk("wt", out_sharp_weight, byp ? 3'h0 : c == 2 ? d3[30:28] :
          c == 1 ? d3[26:24] : d3[22:20]);
        chk("gain", {out_gain, out_noise_est}, {byp ? 6'h0 : d3[19:14], d2[15:8]});
        chk("coef", {out_inner_ring_centre_coef, out_inner_ring_cross_coef,
          out_outer_ring_centre_coef, out_outer_ring_cross_coef},
          {d3[10:6], d3[4:0], d4[30:26], d4[24:20]});
      end
    end
    acc(1'b0, 10'h020, '0, 4'hf);
    chk("stat", rdat, 32'h0003_0018);
    acc(1'b0, 10'h300, '0, 4'hf);
    chk("unmapped", rdat, 0);
    for (int n = 0; n < 8; n++) begin
      rm = 6'($urandom);
      u = 1'($urandom);
      mn = 1'($urandom);
      acc(1'b1, 10'h000, {10'h0, 3'(n), rm, 12'h0, u}, 4'hf);
      beat(2'b00, {4'h0, mn, 50'h0});
      chk("ratio", out_ratio_limit, 2 * n + 2);
      chk("round", out_round_uvr, mn ? {rm[4], rm[2], rm[0]} : {rm[5], rm[3], rm[1]});
      chk("unnorm", out_unnorm_coords, u);
    end
    for (int k = 0; k < 4; k++) begin
      kv = $urandom & 32'h00ff_ffff;
      acc(1'b1, 10'(16 + 4 * k), kv, 4'hf);
      for (int m = 0; m < 4; m++) begin
        acc(1'b1, 10'h000, {6'h0, m != 2, 2'(k), m < 2, 22'h0}, 4'hf);
        acc(1'b1, sa(k, 0), {13'h0, 1'b1, 2'(k), 16'h0}, 4'hf);
        ten = (m == 1);
        q = $urandom;
        hitx = {kv[23:16], q[1:0], kv[15:8], q[3:2], kv[7:0], q[5:4]};
        if (!ten)
          hitx = {2'b0, kv[23:16], 2'b0, kv[15:8], 2'b0, kv[7:0]};
        beat(2'(m == 3 ? k : 0), {m == 3, 4'h0, m != 3, ten, q[31:22], hitx, 8'h0});
        chk("tex", {out_tex_a, out_tex_r, out_tex_g, out_tex_b},
          m == 2 ? {q[31:22], hitx} : ten ? {20'h200, 10'h40, 10'h200}
          : m == 3 ? 40'h0 : {20'h80, 10'h10, 10'h80});
      end
    end
    acc(1'b1, 10'h000, 32'h0380_0000, 4'hf);
    eu.go(2'b00, {7'b0000010, 10'h0, hitx, 8'h0});
    eu.go(2'b00, {7'b0110010, 10'h0, hitx ^ 30'h1, 8'h0});
    eu.idle();
    #1;
    chk("kill", {out_valid, out_pixel_done, out_mask_valid, out_pixel_mask}, 4'b1110);
    beat(2'b00, {7'b0110010, 10'h0, hitx ^ 30'h1, 8'h0});
    chk("clean", {out_mask_valid, out_pixel_mask}, 2'b11);
    beat(2'b00, {7'b0100010, 10'h0, hitx, 8'h0});
    chk("noret", {out_mask_valid, out_pixel_mask}, 2'b01);
    close_out();
  end
endmodule
